// >>> common/adcsc_consts.vh
// constants for the converter control and serial port block
`ifndef ADCSC_CONSTS_VH
`define ADCSC_CONSTS_VH

// ----------------------------------------------------------------
// resolution and field widths
// ----------------------------------------------------------------
`define ADCSC_RES_W        10
`define ADCSC_THR_W        8
`define ADCSC_BYTE_W       8
`define ADCSC_CHAN_W       2
`define ADCSC_BIT_CNT_W    4
`define ADCSC_TMR_W        6

// ----------------------------------------------------------------
// timing: conversion time and per-bit trial time
// ----------------------------------------------------------------
`define ADCSC_CLK_PERIOD_NS 20
`define ADCSC_CONV_TIME_NS  9000
`define ADCSC_CONV_CYCLES   (`ADCSC_CONV_TIME_NS / `ADCSC_CLK_PERIOD_NS)
`define ADCSC_BIT_CYCLES    (`ADCSC_CONV_CYCLES / `ADCSC_RES_W)

// ----------------------------------------------------------------
// control byte decode
// ----------------------------------------------------------------
`define ADCSC_ADDR_CH_MAX  8'h03
`define ADCSC_ADDR_THR     8'h07
`define ADCSC_TEMP_CHAN    2'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADCSC_THR_RST      8'hFF
`define ADCSC_CHAN_RST     2'h0
// pin order: trigger_n, cs_n, rd_wr, sclk, din, comparator
`define ADCSC_SYNC_W       6
`define ADCSC_SYNC_RST     6'h30

`endif

// >>> rtl/adcsc_sync.v
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps

module adcsc_sync #(
    parameter                 W   = 1,
    parameter [W-1:0]         RST = {W{1'b0}}
) (
    input  wire               i_ref_clk,
    input  wire               i_rst,
    input  wire [W-1:0]       i_async,
    output wire [W-1:0]       o_sync
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            stage1 <= RST;
            stage2 <= RST;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;

endmodule // adcsc_sync

// >>> rtl/adcsc_top.v
// conversion control, overtemperature flag and serial port of the converter
`timescale 1ns/100ps
`include "adcsc_consts.vh"

module adcsc_top (
    input  wire                         i_ref_clk,
    input  wire                         i_rst,
    input  wire                         i_conversion_trigger_n,
    input  wire                         i_cs_n,
    input  wire                         i_rd_wr,
    input  wire                         i_sclk,
    input  wire                         i_din,
    input  wire                         i_cmp,
    output reg                          o_dout,
    output reg                          o_dout_oe,
    output reg                          o_busy,
    output reg                          o_hold,
    output reg                          o_power_down,
    output reg                          o_overtemp_flag_n,
    output reg  [`ADCSC_CHAN_W-1:0]     o_channel,
    output reg  [`ADCSC_RES_W-1:0]      o_dac_code
);

    // ----------------------------------------------------------------
    // state encoding
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_CONV = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    // counts worked out as integers, then cut to their counter widths
    localparam integer BIT_LAST_I   = `ADCSC_BIT_CYCLES - 1;
    localparam integer SHIFT_LAST_I = `ADCSC_BYTE_W - 1;
    localparam integer IDX_TOP_I    = `ADCSC_RES_W - 1;

    localparam [`ADCSC_TMR_W-1:0]     BIT_LAST   = BIT_LAST_I[`ADCSC_TMR_W-1:0];
    localparam [`ADCSC_BIT_CNT_W-1:0] SHIFT_LAST = SHIFT_LAST_I[`ADCSC_BIT_CNT_W-1:0];
    localparam [`ADCSC_BIT_CNT_W-1:0] IDX_TOP    = IDX_TOP_I[`ADCSC_BIT_CNT_W-1:0];

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // every pin passes two flops before any logic reads it
    wire [`ADCSC_SYNC_W-1:0] pins_sync;

    adcsc_sync #(
        .W   (`ADCSC_SYNC_W),
        .RST (`ADCSC_SYNC_RST)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   ({i_conversion_trigger_n, i_cs_n, i_rd_wr,
                     i_sclk, i_din, i_cmp}),
        .o_sync    (pins_sync)
    );

    wire trig_n_s = pins_sync[5];
    wire cs_n_s   = pins_sync[4];
    wire rd_wr_s  = pins_sync[3];
    wire sclk_s   = pins_sync[2];
    wire din_s    = pins_sync[1];
    wire cmp_s    = pins_sync[0];

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    // reset values match the idle pin levels: no false edge after reset
    reg trig_n_d;
    reg cs_n_d;
    reg rd_wr_d;
    reg sclk_d;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            trig_n_d <= 1'b1;
            cs_n_d   <= 1'b1;
            rd_wr_d  <= 1'b0;
            sclk_d   <= 1'b0;
        end else begin
            trig_n_d <= trig_n_s;
            cs_n_d   <= cs_n_s;
            rd_wr_d  <= rd_wr_s;
            sclk_d   <= sclk_s;
        end
    end

    wire trig_fall = trig_n_d & ~trig_n_s;
    wire cs_rise   = ~cs_n_d & cs_n_s;
    wire rd_rise   = ~rd_wr_d & rd_wr_s;
    wire rd_fall   = rd_wr_d & ~rd_wr_s;
    wire sclk_rise = ~sclk_d & sclk_s;
    wire sclk_fall = sclk_d & ~sclk_s;
    wire port_sel  = ~cs_n_s;

    // ----------------------------------------------------------------
    // successive approximation sequencer
    // ----------------------------------------------------------------
    reg [2:0]                   state;
    reg [2:0]                   next_state;
    reg [`ADCSC_TMR_W-1:0]      bit_tmr;
    reg [`ADCSC_BIT_CNT_W-1:0]  bit_idx;
    reg [`ADCSC_CHAN_W-1:0]     conv_chan;
    reg [`ADCSC_RES_W-1:0]      result;
    reg [`ADCSC_THR_W-1:0]      overtemp_threshold;
    reg [`ADCSC_CHAN_W-1:0]     chan_reg;

    wire bit_end = (bit_tmr == BIT_LAST);
    wire last_bit = (bit_idx == {`ADCSC_BIT_CNT_W{1'b0}});

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (trig_fall)
                    next_state = ST_CONV;
            end
            ST_CONV: begin
                if (bit_end && last_bit)
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // trial bits, busy, hold and result latch
    // ----------------------------------------------------------------

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            state        <= ST_IDLE;
            bit_tmr      <= {`ADCSC_TMR_W{1'b0}};
            bit_idx      <= {`ADCSC_BIT_CNT_W{1'b0}};
            conv_chan    <= `ADCSC_CHAN_RST;
            o_dac_code   <= {`ADCSC_RES_W{1'b0}};
            o_busy       <= 1'b0;
            o_hold       <= 1'b0;
            o_power_down <= 1'b0;
            result       <= {`ADCSC_RES_W{1'b0}};
        end else begin
            state <= next_state;
            case (state)
                ST_IDLE: begin
                    if (trig_fall) begin
                        conv_chan    <= chan_reg;
                        o_busy       <= 1'b1;
                        o_hold       <= 1'b1;
                        o_power_down <= 1'b0;
                        bit_tmr      <= {`ADCSC_TMR_W{1'b0}};
                        bit_idx      <= IDX_TOP;
                        o_dac_code   <= {1'b1, {(`ADCSC_RES_W-1){1'b0}}};
                    end
                end
                ST_CONV: begin
                    if (bit_end) begin
                        bit_tmr <= {`ADCSC_TMR_W{1'b0}};
                        // comparator low means the trial bit overshoots
                        if (!cmp_s)
                            o_dac_code[bit_idx] <= 1'b0;
                        if (!last_bit) begin
                            bit_idx <= bit_idx - 1'b1;
                            o_dac_code[bit_idx - 1'b1] <= 1'b1;
                        end
                    end else begin
                        bit_tmr <= bit_tmr + 1'b1;
                    end
                end
                ST_DONE: begin
                    // one done cycle lets the final bit land before the latch
                    result       <= o_dac_code;
                    o_busy       <= 1'b0;
                    o_hold       <= 1'b0;
                    o_power_down <= ~trig_n_s;
                end
                default: begin
                    o_busy <= 1'b0;
                    o_hold <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // channel to the analog mux
    // ----------------------------------------------------------------

    always @(posedge i_ref_clk) begin
        if (i_rst)
            o_channel <= `ADCSC_CHAN_RST;
        else
            o_channel <= (state == ST_IDLE) ? chan_reg : conv_chan;
    end

    // ----------------------------------------------------------------
    // overtemperature flag
    // ----------------------------------------------------------------
    // a set in the same cycle as a release wins
    wire over_set = (state == ST_DONE) &&
                    (conv_chan == `ADCSC_TEMP_CHAN) &&
                    (o_dac_code[`ADCSC_RES_W-1 -: `ADCSC_THR_W] >
                     overtemp_threshold);

    always @(posedge i_ref_clk) begin
        if (i_rst)
            o_overtemp_flag_n <= 1'b1;
        else if (over_set)
            o_overtemp_flag_n <= 1'b0;
        else if (rd_rise && port_sel)
            o_overtemp_flag_n <= 1'b1;
    end

    // ----------------------------------------------------------------
    // serial write path
    // ----------------------------------------------------------------
    reg [`ADCSC_BYTE_W-1:0]     wr_shift;
    reg [`ADCSC_BIT_CNT_W-1:0]  wr_cnt;
    reg                         thr_armed;

    wire wr_take = port_sel && !rd_wr_s && sclk_rise;
    wire [`ADCSC_BYTE_W-1:0] wr_byte = {wr_shift[`ADCSC_BYTE_W-2:0], din_s};
    wire wr_done = wr_take && (wr_cnt == SHIFT_LAST);

    // ----------------------------------------------------------------
    // control byte decode
    // ----------------------------------------------------------------
    wire byte_thr_ptr = (wr_byte == `ADCSC_ADDR_THR);
    wire byte_chan    = (wr_byte <= `ADCSC_ADDR_CH_MAX);

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_shift           <= {`ADCSC_BYTE_W{1'b0}};
            wr_cnt             <= {`ADCSC_BIT_CNT_W{1'b0}};
            thr_armed          <= 1'b0;
            chan_reg           <= `ADCSC_CHAN_RST;
            overtemp_threshold <= `ADCSC_THR_RST;
        end else begin
            // bit count restarts on deselect or a turn to read
            if (cs_rise || rd_rise)
                wr_cnt <= {`ADCSC_BIT_CNT_W{1'b0}};
            else if (wr_take) begin
                wr_shift <= wr_byte;
                wr_cnt   <= wr_done ? {`ADCSC_BIT_CNT_W{1'b0}}
                                    : wr_cnt + 1'b1;
            end
            if (wr_done) begin
                if (thr_armed) begin
                    overtemp_threshold <= wr_byte;
                    thr_armed          <= 1'b0;
                end else if (byte_thr_ptr) begin
                    thr_armed <= 1'b1;
                end else if (byte_chan) begin
                    chan_reg <= wr_byte[`ADCSC_CHAN_W-1:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // serial read path
    // ----------------------------------------------------------------
    reg [`ADCSC_RES_W-1:0] rd_shift;

    // deselect or a turn to write frees the pin before anything else

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            rd_shift  <= {`ADCSC_RES_W{1'b0}};
            o_dout    <= 1'b0;
            o_dout_oe <= 1'b0;
        end else if (cs_rise || rd_fall || cs_n_s) begin
            o_dout_oe <= 1'b0;
        end else if (rd_rise) begin
            // read begins with the latched result, msb first
            rd_shift  <= {result[`ADCSC_RES_W-2:0], 1'b0};
            o_dout    <= result[`ADCSC_RES_W-1];
            o_dout_oe <= 1'b1;
        end else if (o_dout_oe && sclk_fall) begin
            o_dout   <= rd_shift[`ADCSC_RES_W-1];
            rd_shift <= {rd_shift[`ADCSC_RES_W-2:0], 1'b0};
        end
    end

endmodule // adcsc_top

// >>> dv/adcsc_monitor.sv
// assertion checker for the converter control block
`timescale 1ns/100ps
module adcsc_monitor (
    input wire       i_ref_clk,
    input wire       i_rst,
    input wire       i_conversion_trigger_n,
    input wire       i_cs_n,
    input wire       i_rd_wr,
    input wire       i_sclk,
    input wire       i_din,
    input wire       i_cmp,
    input wire       o_dout,
    input wire       o_dout_oe,
    input wire       o_busy,
    input wire       o_hold,
    input wire       o_power_down,
    input wire       o_overtemp_flag_n,
    input wire [1:0] o_channel,
    input wire [9:0] o_dac_code
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    reg [9:0] busy_cnt;
    // cycles of busy so far in this conversion
    always @(posedge i_ref_clk) begin
        if (i_rst || !o_busy) busy_cnt <= 10'h000;
        else busy_cnt <= busy_cnt + 10'h001;
    end
    sequence s_trig_lo; !i_conversion_trigger_n [*6]; endsequence
    sequence s_trig_hi; i_conversion_trigger_n [*6]; endsequence
    sequence s_end; $fell(o_busy); endsequence
    property p_start; $fell(i_conversion_trigger_n) && !o_busy |-> ##[1:5] $rose(o_busy); endproperty
    property p_first; $rose(o_busy) |-> o_dac_code == 10'h200 && !o_power_down; endproperty
    // ten 45-clock bit slots plus the done cycle
    property p_busy_len; $fell(o_busy) |-> busy_cnt == 10'h1C3; endproperty
    property p_hold; o_hold == o_busy; endproperty
    property p_pd_on; s_trig_lo ##1 s_end |-> o_power_down; endproperty
    property p_pd_off; s_trig_hi ##1 s_end |-> !o_power_down; endproperty
    property p_release; $rose(o_dout_oe) && !$fell(o_busy) |-> o_overtemp_flag_n; endproperty
    property p_flag; $fell(o_overtemp_flag_n) |-> $fell(o_busy) && o_channel == 2'h0; endproperty
    property p_cs_quiet; i_cs_n [*5] |-> !o_dout_oe; endproperty
    property p_oe_off; $fell(i_rd_wr) || $rose(i_cs_n) |-> ##5 !o_dout_oe; endproperty
    property p_chan; o_busy && $past(o_busy) |-> $stable(o_channel); endproperty
    a_start: assert property (p_start) else $error("busy did not follow trigger fall");
    a_first: assert property (p_first) else $error("bad first trial code");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_hold: assert property (p_hold) else $error("hold differs from busy");
    a_pd_on: assert property (p_pd_on) else $error("power down missing");
    a_pd_off: assert property (p_pd_off) else $error("unexpected power down");
    a_release: assert property (p_release) else $error("flag not released");
    a_flag: assert property (p_flag) else $error("flag fell off a channel zero end");
    a_cs_quiet: assert property (p_cs_quiet) else $error("output driven while deselected");
    a_oe_off: assert property (p_oe_off) else $error("output not released");
    a_chan: assert property (p_chan) else $error("channel moved in conversion");
endmodule // adcsc_monitor

bind adcsc_top adcsc_monitor u_mon (.i_ref_clk, .i_rst, .i_conversion_trigger_n, .i_cs_n,
    .i_rd_wr, .i_sclk, .i_din, .i_cmp, .o_dout, .o_dout_oe, .o_busy, .o_hold, .o_power_down,
    .o_overtemp_flag_n, .o_channel, .o_dac_code);

// >>> dv/adcsc_analog.sv
// analog front end model: comparator against per-channel input levels
`timescale 1ns/100ps
module adcsc_analog (
    input  wire [1:0]  i_channel,
    input  wire [9:0]  i_dac_code,
    input  wire [39:0] i_vin,
    output wire        o_cmp
);
    // keep trial bit while input is at or above trial code
    assign o_cmp = (i_vin[i_channel*10 +: 10] >= i_dac_code);
endmodule // adcsc_analog

// >>> dv/adcsc_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adcsc_top_bench;
    reg i_ref_clk, i_rst, i_conversion_trigger_n, i_cs_n, i_rd_wr, i_sclk, i_din;
    wire i_cmp, o_dout, o_dout_oe, o_busy, o_hold, o_power_down, o_overtemp_flag_n;
    wire [1:0] o_channel;
    wire [9:0] o_dac_code;
    reg [39:0] vin;
    reg [9:0] got, v;
    reg [7:0] thr;
    integer error_cnt, checked, i, k;
    adcsc_top DUT (.i_ref_clk, .i_rst, .i_conversion_trigger_n, .i_cs_n, .i_rd_wr, .i_sclk,
        .i_din, .i_cmp, .o_dout, .o_dout_oe, .o_busy, .o_hold, .o_power_down,
        .o_overtemp_flag_n, .o_channel, .o_dac_code);
    adcsc_analog u_analog (.i_channel(o_channel), .i_dac_code(o_dac_code), .i_vin(vin),
        .o_cmp(i_cmp));
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function exp_flag_n(input [1:0] ch, input [9:0] val, input [7:0] t);
        exp_flag_n = !(ch == 2'h0 && val[9:2] > t);
    endfunction
    task report_and_stop;
        $display("counts: checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task check(input [15:0] a, input [15:0] b);
        checked = checked + 1;
        if (a !== b) begin
            $display("BAD t=%0t got=%h exp=%h", $time, a, b);
            error_cnt = error_cnt + 1;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task wait_busy(input lvl);
        integer n;
        for (n = 0; n < 600 && o_busy !== lvl; n = n + 1) tick(1);
        if (o_busy !== lvl) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    endtask
    task wr(input [7:0] b, input csv);
        i_cs_n = csv;
        i_rd_wr = 1'b0;
        tick(4);
        for (k = 7; k >= 0; k = k - 1) begin
            i_din = b[k];
            tick(4);
            i_sclk = 1'b1;
            tick(4);
            i_sclk = 1'b0;
        end
        tick(4);
        i_cs_n = 1'b1;
        tick(4);
    endtask
    task rd(output [9:0] r);
        i_cs_n = 1'b0;
        tick(4);
        i_rd_wr = 1'b1;
        tick(6);
        check(o_dout_oe, 1'b1);
        for (k = 9; k >= 0; k = k - 1) begin
            r[k] = o_dout;
            if (k > 0) begin
                i_sclk = 1'b1;
                tick(4);
                i_sclk = 1'b0;
                tick(6);
            end
        end
        i_rd_wr = 1'b0;
        tick(6);
        check(o_dout_oe, 1'b0);
        i_cs_n = 1'b1;
        tick(4);
    endtask
    task conv(input [1:0] ch, input [9:0] val, input lo);
        vin[ch*10 +: 10] = val;
        i_conversion_trigger_n = 1'b0;
        tick(2);
        i_conversion_trigger_n = !lo;
        wait_busy(1'b1);
        wait_busy(1'b0);
        tick(1);
        check(o_power_down, lo);
        check(o_channel, ch);
        i_conversion_trigger_n = 1'b1;
        tick(4);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        error_cnt = 0;
        checked = 0;
        {i_rst, i_conversion_trigger_n, i_cs_n, i_rd_wr, i_sclk, i_din} = 6'h38;
        vin = 40'h0;
        thr = 8'hFF;
        v = $urandom(32'hD9070D69);
        tick(6);
        i_rst = 1'b0;
        tick(2);
        check({o_busy, o_hold, o_power_down, o_overtemp_flag_n, o_channel, o_dout_oe}, 7'h08);
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1) begin
            v = $urandom;
            wr(i[7:0], 1'b0);
            conv(i[1:0], v, i[0]);
            check(o_overtemp_flag_n, exp_flag_n(i[1:0], v, thr));
            rd(got);
            check(got, v);
        end
        $display("test channels done");
        wr(8'h00, 1'b0);
        wr(8'h07, 1'b0);
        thr = $urandom % 255;
        wr(thr, 1'b0);
        conv(2'h0, {thr, 2'h3}, 1'b0);
        check(o_overtemp_flag_n, exp_flag_n(2'h0, {thr, 2'h3}, thr));
        v = {thr + 8'h01, 2'h0};
        conv(2'h0, v, 1'b0);
        check(o_overtemp_flag_n, exp_flag_n(2'h0, v, thr));
        i_rd_wr = 1'b1;
        tick(6);
        i_rd_wr = 1'b0;
        tick(6);
        check({o_overtemp_flag_n, o_dout_oe}, 2'h0);
        rd(got);
        check(got, v);
        check(o_overtemp_flag_n, 1'b1);
        $display("test overtemp done");
        wr(8'h03, 1'b1);
        check(o_channel, 2'h0);
        wr(8'h05, 1'b0);
        check(o_channel, 2'h0);
        vin[9:0] = 10'h000;
        i_conversion_trigger_n = 1'b0;
        tick(2);
        i_conversion_trigger_n = 1'b1;
        wait_busy(1'b1);
        i_conversion_trigger_n = 1'b0;
        tick(8);
        i_conversion_trigger_n = 1'b1;
        rd(got);
        check(got, v);
        wait_busy(1'b0);
        tick(4);
        rd(got);
        check(got, 10'h000);
        $display("test latch done");
        report_and_stop;
    end
endmodule // adcsc_top_bench
